// *** dpdc_ext_src.sv ***
/*
 Model of the outside source that drives the external timer input pin.
 Assumes it runs off the core clock and changes the pin just after edges.
*/
`timescale 1ns/10ps
module dpdc_ext_src (
   input  wire logic       core_clk_in,
   input  wire logic       run_in,
   input  wire logic       idle_in,
   input  wire logic [7:0] half_in,
   output logic            ext_out
);
   int   lim;
   int   cnt_r;
   ////////////////////////////////////////////////////////////////////////
   // Half period is never shorter than the 1 MHz ceiling allows
   assign lim = (int'(half_in) > (dpdc_pkg::EXT_MIN_CYC + 1) / 2) ?
                int'(half_in) : (dpdc_pkg::EXT_MIN_CYC + 1) / 2;
   initial begin
      ext_out = 1'b0;
      cnt_r   = 0;
   end
   always @(posedge core_clk_in) begin
      if (!run_in) begin
         ext_out <= idle_in;
         cnt_r   <= 0;
      end else if (cnt_r >= lim - 1) begin
         ext_out <= !ext_out;
         cnt_r   <= 0;
      end else begin
         cnt_r   <= cnt_r + 1;
      end
   end
endmodule // dpdc_ext_src

// *** dpdc_pkg.sv ***
/*
 Package for the dual prescaled down counter block: APB register map,
 field positions, reset values and timing figures.
 Assumes a 32-bit APB bus with word-aligned registers.
*/
package dpdc_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL      = 8'h00;
   localparam logic [7:0] OFF_MODE      = 8'h04;
   localparam logic [7:0] OFF_PRE0      = 8'h08;
   localparam logic [7:0] OFF_PRE1      = 8'h0c;
   localparam logic [7:0] OFF_LOAD0     = 8'h10;
   localparam logic [7:0] OFF_LOAD1     = 8'h14;
   localparam logic [7:0] OFF_CNT0      = 8'h18;
   localparam logic [7:0] OFF_CNT1      = 8'h1c;
   localparam logic [7:0] OFF_IRQ_STAT  = 8'h20;
   localparam logic [7:0] OFF_IRQ_MASK  = 8'h24;
   // Control register: per timer enable, load strobe, continuous mode
   localparam int CTRL_EN0   = 0;
   localparam int CTRL_LD0   = 1;
   localparam int CTRL_CONT0 = 2;
   localparam int CTRL_EN1   = 3;
   localparam int CTRL_LD1   = 4;
   localparam int CTRL_CONT1 = 5;
   // Mode register fields
   localparam int MODE_EXT_LO     = 0;  // 2 bits: 0 int,1 clock,2 gate,3 trigger
   localparam int MODE_RETRIG     = 2;
   localparam int MODE_CASCADE    = 3;
   localparam int MODE_OUT_LO     = 4;  // 2 bits: 0 off,1 timer0,2 timer1,3 clock
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] MODE_RST = 32'h0000_0000;
   // Internal clock divided by four feeds timer one when internal
   localparam int INT_DIV = 4;
   // External clock ceiling 1 MHz: minimum period in ns, and in cycles at 25 MHz
   localparam int CLK_PERIOD_NS = 40;
   localparam int EXT_MIN_PERIOD_NS = 1000;
   localparam int EXT_MIN_CYC = (EXT_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   typedef enum logic [1:0] {
      DPDC_EXT_NONE, DPDC_EXT_CLOCK, DPDC_EXT_GATE, DPDC_EXT_TRIG
   } dpdc_ext_t;
endpackage

// *** dpdc_timer.sv ***
/*
 Dual 8-bit down counters, each behind a 6-bit prescaler, with APB
 registers, sticky interrupt status, external input and output pin.
 Assumes timer_ext_input is asynchronous to core_clk_in.
*/
`timescale 1ns/10ps
// Notes on behaviour
// - Two independent 8-bit counters, each with its own 6-bit prescaler
// - Timer one prescaler takes internal or external clock; timer zero internal only
// - Prescalers divide their input by 1 to 64 and clock their counter
// - Counters decrement a loaded value; range 1 to 256 (0 means 256)
// - End of count raises a separate request per timer
// - Software starts, stops, resumes or restarts from initial value
// - Single-pass halts at zero; continuous reloads and keeps counting
// - Counters readable without disturbance; prescalers read as zero
// - Timer one internal source is the core clock divided by four
// - External input acts as clock, trigger (retriggerable or not) or gate
// - Cascade routes timer zero end-of-count into timer one
// - Output pin shows timer zero, timer one or internal clock
module dpdc_timer (
   input  wire logic        core_clk_in,
   input  wire logic        rst_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   input  wire logic        timer_ext_input_in,
   output logic             timer_output_pin_out,
   output logic             timer_zero_request_out,
   output logic             timer_one_request_out,
   output logic             irq_out
);
   ////////////////////////////////////////////////////////////////////////
   // Bus decode
   logic [31:0] ctrl_r, mode_r;
   logic [5:0]  pre0_r, pre1_r;
   logic [7:0]  load0_r, load1_r, cnt0_r, cnt1_r;
   logic [5:0]  pdiv0_r, pdiv1_r;
   logic [1:0]  stat_r, mask_r;
   logic [1:0]  div4_r;
   logic        ext_s1_r, ext_s2_r, ext_d_r, trig_run_r, pin_r;
   logic        eoc0_r, eoc1_r;
   logic        done0_r, done1_r;

   wire wr_en = psel_in && penable_in && pwrite_in;
   wire rd_ok = (paddr_in[1:0] == 2'b00) && (paddr_in <= dpdc_pkg::OFF_IRQ_MASK);
   wire wr_ctrl  = wr_en && paddr_in == dpdc_pkg::OFF_CTRL;
   wire wr_mode  = wr_en && paddr_in == dpdc_pkg::OFF_MODE;
   wire wr_pre0  = wr_en && paddr_in == dpdc_pkg::OFF_PRE0;
   wire wr_pre1  = wr_en && paddr_in == dpdc_pkg::OFF_PRE1;
   wire wr_load0 = wr_en && paddr_in == dpdc_pkg::OFF_LOAD0;
   wire wr_load1 = wr_en && paddr_in == dpdc_pkg::OFF_LOAD1;
   wire wr_stat  = wr_en && paddr_in == dpdc_pkg::OFF_IRQ_STAT;
   wire wr_mask  = wr_en && paddr_in == dpdc_pkg::OFF_IRQ_MASK;

   // Zero-wait slave; unmapped addresses answer with an error
   assign pready_out  = 1'b1;
   assign pslverr_out = psel_in && penable_in && !rd_ok;

   logic [31:0] rd_mux;
   always_comb begin
      case (paddr_in)
         dpdc_pkg::OFF_CTRL:     rd_mux = ctrl_r;
         dpdc_pkg::OFF_MODE:     rd_mux = mode_r;
         dpdc_pkg::OFF_LOAD0:    rd_mux = {24'h00_0000, load0_r};
         dpdc_pkg::OFF_LOAD1:    rd_mux = {24'h00_0000, load1_r};
         dpdc_pkg::OFF_CNT0:     rd_mux = {24'h00_0000, cnt0_r};
         dpdc_pkg::OFF_CNT1:     rd_mux = {24'h00_0000, cnt1_r};
         dpdc_pkg::OFF_IRQ_STAT: rd_mux = {30'h0000_0000, stat_r};
         dpdc_pkg::OFF_IRQ_MASK: rd_mux = {30'h0000_0000, mask_r};
         default:                rd_mux = 32'h0000_0000; // Prescalers read zero
      endcase
   end
   assign prdata_out = rd_mux;

   ////////////////////////////////////////////////////////////////////////
   // Configuration registers
   wire en0   = ctrl_r[dpdc_pkg::CTRL_EN0];
   wire en1   = ctrl_r[dpdc_pkg::CTRL_EN1];
   wire cont0 = ctrl_r[dpdc_pkg::CTRL_CONT0];
   wire cont1 = ctrl_r[dpdc_pkg::CTRL_CONT1];
   wire ld0   = wr_ctrl && pwdata_in[dpdc_pkg::CTRL_LD0];
   wire ld1   = wr_ctrl && pwdata_in[dpdc_pkg::CTRL_LD1];
   wire [1:0] ext_mode = mode_r[dpdc_pkg::MODE_EXT_LO +: 2];
   wire       retrig   = mode_r[dpdc_pkg::MODE_RETRIG];
   wire       cascade  = mode_r[dpdc_pkg::MODE_CASCADE];
   wire [1:0] out_sel  = mode_r[dpdc_pkg::MODE_OUT_LO +: 2];

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         ctrl_r  <= dpdc_pkg::CTRL_RST;
         mode_r  <= dpdc_pkg::MODE_RST;
         pre0_r  <= 6'h00;
         pre1_r  <= 6'h00;
         load0_r <= 8'h00;
         load1_r <= 8'h00;
         mask_r  <= 2'h0;
      end else begin
         // Load strobes are self-clearing so they read back as zero
         if (wr_ctrl) ctrl_r <= pwdata_in & 32'h0000_002d;
         if (wr_mode) mode_r <= pwdata_in & 32'h0000_003f;
         if (wr_pre0) pre0_r <= pwdata_in[5:0];
         if (wr_pre1) pre1_r <= pwdata_in[5:0];
         if (wr_load0) load0_r <= pwdata_in[7:0];
         if (wr_load1) load1_r <= pwdata_in[7:0];
         if (wr_mask) mask_r <= pwdata_in[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // External input: two-flop synchroniser, then edge detect on stage two
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         ext_d_r  <= 1'b0;
      end else begin
         ext_s1_r <= timer_ext_input_in;
         ext_s2_r <= ext_s1_r;
         ext_d_r  <= ext_s2_r;
      end
   end
   wire ext_fall = ext_d_r && !ext_s2_r;

   // Core clock divided by four for timer one's internal source
   always_ff @(posedge core_clk_in) begin
      if (rst_in) div4_r <= 2'h0;
      else div4_r <= div4_r + 2'h1;
   end
   wire int_tick = (div4_r == 2'(dpdc_pkg::INT_DIV - 1));

   // Trigger: falling edge starts counting; retrigger reloads if allowed
   wire trig_mode = (ext_mode == 2'(dpdc_pkg::DPDC_EXT_TRIG));
   wire trig_hit  = trig_mode && ext_fall && (retrig || !trig_run_r);
   always_ff @(posedge core_clk_in) begin
      if (rst_in) trig_run_r <= 1'b0;
      else if (trig_hit) trig_run_r <= 1'b1;
      else if (eoc1_r && !cont1) trig_run_r <= 1'b0;
   end

   logic src1;
   always_comb begin
      case (ext_mode)
         2'(dpdc_pkg::DPDC_EXT_CLOCK): src1 = ext_fall;
         2'(dpdc_pkg::DPDC_EXT_GATE):  src1 = int_tick && ext_s2_r;
         2'(dpdc_pkg::DPDC_EXT_TRIG):  src1 = int_tick && trig_run_r;
         default:                      src1 = int_tick;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Prescalers: a value of 0 wraps through 63 before its tick, so it divides by 64
   wire pclk0_in = en0;
   wire pclk1_in = en1 && (cascade ? eoc0_r : src1);
   wire ptick0 = pclk0_in && (pdiv0_r == 6'h01);
   wire ptick1 = pclk1_in && (pdiv1_r == 6'h01);
   wire [5:0] pdiv0_nxt = ptick0 ? pre0_r : pdiv0_r - 6'h01;
   wire [5:0] pdiv1_nxt = ptick1 ? pre1_r : pdiv1_r - 6'h01;
   always_ff @(posedge core_clk_in) begin
      if (rst_in) pdiv0_r <= 6'h00;
      else if (ld0) pdiv0_r <= pre0_r;
      else if (pclk0_in) pdiv0_r <= pdiv0_nxt;
   end
   always_ff @(posedge core_clk_in) begin
      if (rst_in) pdiv1_r <= 6'h00;
      else if (ld1 || trig_hit) pdiv1_r <= pre1_r;
      else if (pclk1_in) pdiv1_r <= pdiv1_nxt;
   end

   ////////////////////////////////////////////////////////////////////////
   // Counters: load 0 counts 256; end of count when stepping from 1
   // Zero steps on to ff in both modes; only the done flag parks a finished single pass
   wire end0 = ptick0 && (cnt0_r == 8'h01);
   wire end1 = ptick1 && (cnt1_r == 8'h01);
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         cnt0_r  <= 8'h00;
         eoc0_r  <= 1'b0;
         done0_r <= 1'b0;
      end else begin
         eoc0_r <= end0;
         if (ld0) begin
            cnt0_r  <= load0_r;
            done0_r <= 1'b0;
         end else if (end0) begin
            cnt0_r  <= cont0 ? load0_r : 8'h00;
            done0_r <= !cont0;
         end else if (ptick0 && !done0_r) begin
            cnt0_r <= cnt0_r - 8'h01;
         end
      end
   end
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         cnt1_r  <= 8'h00;
         eoc1_r  <= 1'b0;
         done1_r <= 1'b0;
      end else begin
         eoc1_r <= end1;
         if (ld1 || trig_hit) begin
            cnt1_r  <= load1_r;
            done1_r <= 1'b0;
         end else if (end1) begin
            cnt1_r  <= cont1 ? load1_r : 8'h00;
            done1_r <= !cont1;
         end else if (ptick1 && !done1_r) begin
            cnt1_r <= cnt1_r - 8'h01;
         end
      end
   end

   // A finished single pass waits at zero for the next load strobe or trigger
   // Request lines are one-cycle pulses
   assign timer_zero_request_out = eoc0_r;
   assign timer_one_request_out  = eoc1_r;

   ////////////////////////////////////////////////////////////////////////
   // Sticky status, set wins over write-one clear
   always_ff @(posedge core_clk_in) begin
      if (rst_in) stat_r <= 2'h0;
      else stat_r <= (stat_r & ~(wr_stat ? pwdata_in[1:0] : 2'h0)) | {eoc1_r, eoc0_r};
   end
   assign irq_out = |(stat_r & mask_r);

   // Output pin toggles on each end of count, or shows the divided clock
   always_ff @(posedge core_clk_in) begin
      if (rst_in) pin_r <= 1'b0;
      else begin
         case (out_sel)
            2'h1:    pin_r <= pin_r ^ eoc0_r;
            2'h2:    pin_r <= pin_r ^ eoc1_r;
            2'h3:    pin_r <= div4_r[1];
            default: pin_r <= 1'b0;
         endcase
      end
   end
   assign timer_output_pin_out = pin_r;

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   a_single_pass_halt: assert property (@(posedge core_clk_in) disable iff (rst_in)
      end0 && !cont0 && !ld0 |=> cnt0_r == 8'h00 && eoc0_r)
      else $error("timer zero did not halt at zero");
   a_cont_reload: assert property (@(posedge core_clk_in) disable iff (rst_in)
      end1 && cont1 && !ld1 && !trig_hit |=> cnt1_r == $past(load1_r))
      else $error("timer one did not reload on end of count");
   a_count_step: assert property (@(posedge core_clk_in) disable iff (rst_in)
      ptick0 && !ld0 && cnt0_r > 8'h01 |=> cnt0_r == $past(cnt0_r) - 8'h01)
      else $error("timer zero did not decrement");
   a_hold_stop: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !en0 && !ld0 |=> $stable(cnt0_r))
      else $error("stopped timer zero changed");
   a_request_pulse: assert property (@(posedge core_clk_in) disable iff (rst_in)
      end1 |=> timer_one_request_out ##1 stat_r[1])
      else $error("timer one request missing");
   a_cascade_feed: assert property (@(posedge core_clk_in) disable iff (rst_in)
      cascade && en1 && !ld1 && !trig_hit && !eoc0_r |=> $stable(cnt1_r))
      else $error("cascaded timer one moved without timer zero");
   a_pre_read_zero: assert property (@(posedge core_clk_in) disable iff (rst_in)
      paddr_in == dpdc_pkg::OFF_PRE0 |-> prdata_out == 32'h0000_0000)
      else $error("prescaler readable");
   a_div_by_one: assert property (@(posedge core_clk_in) disable iff (rst_in)
      en0 && pre0_r == 6'h01 && pdiv0_r == 6'h01 && !ld0 |-> ptick0)
      else $error("divide by one missed a tick");
   a_irq_level: assert property (@(posedge core_clk_in) disable iff (rst_in)
      stat_r[0] && mask_r[0] |-> irq_out)
      else $error("masked-in status did not raise irq");
   c_zero_end: cover property (@(posedge core_clk_in) end0);
   c_one_cont: cover property (@(posedge core_clk_in) end1 && cont1);
   c_trig: cover property (@(posedge core_clk_in) trig_hit);
   c_ext_clock: cover property (@(posedge core_clk_in) ext_mode == 2'(dpdc_pkg::DPDC_EXT_CLOCK) && ptick1);
   c_cascade: cover property (@(posedge core_clk_in) cascade && ptick1);

   ////////////////////////////////////////////////////////////////////////
   // Prescaler and counter stepping
   a_pre_load_copy: assert property (@(posedge core_clk_in) disable iff (rst_in)
      ld0 |=> pdiv0_r == $past(pre0_r))
      else $error("prescaler zero not loaded by strobe");
   a_pre_step_down: assert property (@(posedge core_clk_in) disable iff (rst_in)
      pclk0_in && !ld0 && !ptick0 |=> pdiv0_r == $past(pdiv0_r) - 6'h01)
      else $error("prescaler zero did not step down");
   a_pre_tick_reload: assert property (@(posedge core_clk_in) disable iff (rst_in)
      ptick0 && !ld0 |=> pdiv0_r == $past(pre0_r))
      else $error("prescaler zero did not reload on tick");
   a_pre_one_load: assert property (@(posedge core_clk_in) disable iff (rst_in)
      ld1 || trig_hit |=> pdiv1_r == $past(pre1_r))
      else $error("prescaler one not loaded by strobe or trigger");
   a_pre_one_hold: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !pclk1_in && !ld1 && !trig_hit |=> $stable(pdiv1_r))
      else $error("prescaler one moved without input");
   a_zero_wrap: assert property (@(posedge core_clk_in) disable iff (rst_in)
      ptick0 && !ld0 && cnt0_r == 8'h00 && !done0_r |=> cnt0_r == 8'hff)
      else $error("zero load did not count 256");
   a_one_step: assert property (@(posedge core_clk_in) disable iff (rst_in)
      ptick1 && !ld1 && !trig_hit && cnt1_r > 8'h01 |=> cnt1_r == $past(cnt1_r) - 8'h01)
      else $error("timer one did not decrement");
   a_load_copy: assert property (@(posedge core_clk_in) disable iff (rst_in)
      ld1 |=> cnt1_r == $past(load1_r))
      else $error("timer one load strobe ignored");
   a_one_stopped: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !en1 && !ld1 && !trig_hit |=> $stable(cnt1_r))
      else $error("stopped timer one changed");
   a_halt_park: assert property (@(posedge core_clk_in) disable iff (rst_in)
      done0_r && !ld0 |=> cnt0_r == 8'h00 && !timer_zero_request_out)
      else $error("finished single pass moved again");
   a_zero_reload: assert property (@(posedge core_clk_in) disable iff (rst_in)
      end0 && cont0 && !ld0 |=> cnt0_r == $past(load0_r))
      else $error("timer zero did not reload on end of count");
   a_count_readonly: assert property (@(posedge core_clk_in) disable iff (rst_in)
      wr_en && paddr_in == dpdc_pkg::OFF_CNT0 && !pclk0_in && !ld0 |=> $stable(cnt0_r))
      else $error("count register took a write");

   ////////////////////////////////////////////////////////////////////////
   // Requests and sticky status
   a_zero_request: assert property (@(posedge core_clk_in) disable iff (rst_in)
      end0 |=> timer_zero_request_out)
      else $error("timer zero request missing");
   a_no_stray_request: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !end0 |=> !timer_zero_request_out)
      else $error("timer zero request without end of count");
   a_stat_sticky: assert property (@(posedge core_clk_in) disable iff (rst_in)
      stat_r[0] && !(wr_stat && pwdata_in[0]) |=> stat_r[0])
      else $error("status bit dropped without a clear");
   a_stat_clear: assert property (@(posedge core_clk_in) disable iff (rst_in)
      wr_stat && pwdata_in[1] && !eoc1_r |=> !stat_r[1])
      else $error("write one did not clear status");
   a_set_wins: assert property (@(posedge core_clk_in) disable iff (rst_in)
      eoc0_r |=> stat_r[0])
      else $error("end of count lost against a clear");

   ////////////////////////////////////////////////////////////////////////
   // Clock sources and output pin
   a_int_rate: assert property (@(posedge core_clk_in) disable iff (rst_in)
      int_tick |=> !int_tick ##1 !int_tick ##1 !int_tick ##1 int_tick)
      else $error("internal tick not every fourth cycle");
   a_gate_closed: assert property (@(posedge core_clk_in) disable iff (rst_in)
      ext_mode == 2'(dpdc_pkg::DPDC_EXT_GATE) && !ext_s2_r && !cascade |-> !pclk1_in)
      else $error("closed gate let a tick through");
   a_ext_edge: assert property (@(posedge core_clk_in) disable iff (rst_in)
      ext_mode == 2'(dpdc_pkg::DPDC_EXT_CLOCK) && !cascade && en1 && ext_fall |-> pclk1_in)
      else $error("external clock edge not counted");
   a_trig_once: assert property (@(posedge core_clk_in) disable iff (rst_in)
      trig_mode && trig_run_r && !retrig |-> !trig_hit)
      else $error("non-retriggerable trigger restarted");
   a_cascade_tick: assert property (@(posedge core_clk_in) disable iff (rst_in)
      cascade && en1 && eoc0_r |-> pclk1_in)
      else $error("cascade lost a timer zero pulse");
   a_pin_clock: assert property (@(posedge core_clk_in) disable iff (rst_in)
      out_sel == 2'h3 |=> timer_output_pin_out == ($past(div4_r) >= 2'h2))
      else $error("output pin does not follow divided clock");
   a_pin_toggle: assert property (@(posedge core_clk_in) disable iff (rst_in)
      out_sel == 2'h1 && eoc0_r |=> $changed(timer_output_pin_out))
      else $error("output pin did not toggle on end of count");
endmodule // dpdc_timer

// *** dpdc_timer_test.sv ***
/*
 Self-checking bench for the dual down counters: APB master, period model.
 Assumes a zero-wait APB slave and the external source model beside it.
*/
`timescale 1ns/10ps
module dpdc_timer_test;
   logic core_clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, half;
   logic [31:0] pwdata, prdata, q;
   logic ext, pin, zero_req, one_req, irq, run, idle, e;
   int err_total, checks, c, c1, p, n, seed;
   localparam logic [31:0] EN0 = 32'h1 << dpdc_pkg::CTRL_EN0;
   localparam logic [31:0] LD0 = 32'h1 << dpdc_pkg::CTRL_LD0;
   localparam logic [31:0] CT0 = 32'h1 << dpdc_pkg::CTRL_CONT0;
   localparam logic [31:0] ONE_RUN = (32'h1 << dpdc_pkg::CTRL_EN1)
                                    | (32'h1 << dpdc_pkg::CTRL_LD1)
                               | (32'h1 << dpdc_pkg::CTRL_CONT1);
   dpdc_timer uut (.core_clk_in(core_clk), .rst_in(rst), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .timer_ext_input_in(ext),
      .timer_output_pin_out(pin), .timer_zero_request_out(zero_req),
      .timer_one_request_out(one_req), .irq_out(irq));
   dpdc_ext_src src (.core_clk_in(core_clk), .run_in(run), .idle_in(idle), .half_in(half),
      .ext_out(ext));
   ////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = !core_clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
         err_total++;
      end
   endtask
   task automatic tally_and_finish;
      $display("mismatches=%0d comparisons=%0d", err_total, checks);
      if (err_total == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Period between two events: 0 zero request, 1 one request, 2 pin change; 0 on timeout
   task automatic measure(input int sel, input int lim, output int cyc);
      int k;
      logic pv, hit;
      k = 0;
      pv = pin;
      repeat (2) begin
         hit = 1'b0;
         cyc = 0;
         while (!hit && k < lim) begin
            @(negedge core_clk);
            k++;
            cyc++;
            hit = (sel == 0) ? zero_req === 1'b1 : (sel == 1) ? one_req === 1'b1 : pin !== pv;
            pv = pin;
         end
      end
      if (!hit) cyc = 0;
   endtask
   initial begin
      repeat (30000) @(posedge core_clk);
      err_total++;
      tally_and_finish();
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {psel, penable, pwrite, paddr, pwdata, run, idle} = '0;
      half = 8'h0f;
      seed = 50739;
      rst = 1'b1;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      apb(1'b0, dpdc_pkg::OFF_CNT0, 32'h0);
      check(q, 32'h0);
      apb(1'b0, 8'h30, 32'h0);
      check({31'h0, e}, 32'h1);
      check(q, 32'h0);
      apb(1'b1, dpdc_pkg::OFF_PRE0, 32'h5);
      apb(1'b0, dpdc_pkg::OFF_PRE0, 32'h0);
      check(q, 32'h0);
      for (int i = 0; i < 5; i++) begin
         p = (i == 0) ? 64 : (i == 1) ? 1 : ($unsigned($random(seed)) % 4) + 1;
         n = (i == 0) ? 1 : (i == 1) ? 256 : ($unsigned($random(seed)) % 5) + 1;
         apb(1'b1, dpdc_pkg::OFF_PRE0, p % 64);
         apb(1'b1, dpdc_pkg::OFF_LOAD0, n % 256);
         apb(1'b1, dpdc_pkg::OFF_CTRL, LD0 | EN0 | CT0);
         measure(0, 2000, c);
         check(c, p * n);
      end
      apb(1'b1, dpdc_pkg::OFF_MODE, 32'h10);
      measure(2, 2000, c);
      check(c, p * n);
      apb(1'b1, dpdc_pkg::OFF_MODE, 32'h30);
      measure(2, 100, c);
      check(c, 2);
      apb(1'b1, dpdc_pkg::OFF_MODE, 32'h0);
      apb(1'b1, dpdc_pkg::OFF_PRE1, 32'h3);
      apb(1'b1, dpdc_pkg::OFF_LOAD1, 32'h2);
      apb(1'b1, dpdc_pkg::OFF_CTRL, ONE_RUN);
      measure(1, 500, c);
      check(c, dpdc_pkg::INT_DIV * 6);
      apb(1'b1, dpdc_pkg::OFF_PRE0, 32'h2);
      apb(1'b1, dpdc_pkg::OFF_LOAD0, 32'h3);
      apb(1'b1, dpdc_pkg::OFF_PRE1, 32'h2);
      apb(1'b1, dpdc_pkg::OFF_MODE, 32'h8);
      apb(1'b1, dpdc_pkg::OFF_CTRL, ONE_RUN | LD0 | EN0 | CT0);
      measure(1, 500, c);
      check(c, 24);
      @(posedge core_clk);
      run <= 1'b1;
      apb(1'b1, dpdc_pkg::OFF_MODE, 32'h1);
      apb(1'b1, dpdc_pkg::OFF_PRE1, 32'h1);
      apb(1'b1, dpdc_pkg::OFF_LOAD1, 32'h3);
      apb(1'b1, dpdc_pkg::OFF_CTRL, ONE_RUN);
      measure(1, 1000, c);
      check(c, 90);
      @(posedge core_clk);
      run <= 1'b0;
      apb(1'b1, dpdc_pkg::OFF_MODE, 32'h2);
      measure(1, 200, c);
      check(c, 0);
      @(posedge core_clk);
      idle <= 1'b1;
      measure(1, 200, c);
      check(c, dpdc_pkg::INT_DIV * 3);
      apb(1'b1, dpdc_pkg::OFF_CTRL, LD0 | EN0);
      apb(1'b1, dpdc_pkg::OFF_IRQ_STAT, 32'h3);
      measure(0, 100, c);
      check(c, 0);
      apb(1'b0, dpdc_pkg::OFF_CNT0, 32'h0);
      check(q, 32'h0);
      apb(1'b0, dpdc_pkg::OFF_IRQ_STAT, 32'h0);
      check(q, 32'h1);
      check({31'h0, irq}, 32'h0);
      apb(1'b1, dpdc_pkg::OFF_IRQ_MASK, 32'h1);
      @(negedge core_clk);
      check(irq, 1'b1);
      apb(1'b1, dpdc_pkg::OFF_IRQ_STAT, 32'h1);
      @(negedge core_clk);
      check(irq, 1'b0);
      apb(1'b1, dpdc_pkg::OFF_PRE0, 32'h1);
      apb(1'b1, dpdc_pkg::OFF_LOAD0, 32'hc8);
      apb(1'b1, dpdc_pkg::OFF_CTRL, LD0 | EN0);
      apb(1'b1, dpdc_pkg::OFF_CTRL, 32'h0);
      apb(1'b0, dpdc_pkg::OFF_CNT0, 32'h0);
      c1 = q;
      apb(1'b0, dpdc_pkg::OFF_CNT0, 32'h0);
      check(q, c1);
      apb(1'b1, dpdc_pkg::OFF_CTRL, EN0);
      apb(1'b0, dpdc_pkg::OFF_CNT0, 32'h0);
      check(q < c1 && q > 0, 1'b1);
      tally_and_finish();
   end
endmodule // dpdc_timer_test
